/* fdrd_drive_model.sv */
// behavioural disk drive answering sector searches with sector bytes
`timescale 1ns/10ps
module fdrd_drive_model (
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// search request
	input  wire logic       i_sector_req,
	input  wire logic [7:0] i_req_sector,
	input  wire logic [7:0] i_req_size,
	// pacing and fault control
	input  wire logic [2:0] i_gap,
	input  wire logic       i_crc_bad,
	// answers
	output logic            o_id_found,
	output logic            o_disk_valid,
	output logic [7:0]      o_disk_byte,
	output logic            o_crc_done,
	output logic            o_crc_error
);
	int         len;
	logic [7:0] sec;
	initial begin
		o_id_found = 1'b0;
		o_disk_valid = 1'b0;
		o_disk_byte = 8'h00;
		o_crc_done = 1'b0;
		o_crc_error = 1'b0;
	end
	// one search at a time; byte line inverts between bytes so stale data never matches
	always begin
		@(posedge i_clock);
		if (!i_rst && i_sector_req) begin
			sec = i_req_sector;
			len = 128 << i_req_size[2:0];
			repeat (i_gap) @(posedge i_clock);
			#1 o_id_found = 1'b1;
			@(posedge i_clock);
			#1 o_id_found = 1'b0;
			// whole sector streams even after terminal count
			for (int i = 0; i < len; i++) begin
				repeat (i_gap - 1) @(posedge i_clock);
				#1 o_disk_valid = 1'b1;
				o_disk_byte = (sec * 8'h11) ^ i[7:0];
				@(posedge i_clock);
				#1 o_disk_valid = 1'b0;
				o_disk_byte = ~o_disk_byte;
			end
			o_crc_done = 1'b1;
			o_crc_error = i_crc_bad;
			@(posedge i_clock);
			#1 o_crc_done = 1'b0;
			o_crc_error = 1'b0;
		end
	end
endmodule // fdrd_drive_model

/* fdrd_pkg.sv */
// constants and types for the read-data command sequencer
package fdrd_pkg;
	localparam logic [3:0] FDRD_CMD_LAST    = 4'h8;
	localparam logic [2:0] FDRD_RES_LEN     = 3'h7;
	localparam logic [2:0] FDRD_RES_INVALID = 3'h1;
	localparam logic [4:0] FDRD_OP_READ     = 5'h06;
	localparam int         FDRD_OP_MSB      = 4;
	localparam int         FDRD_MT_BIT      = 7;
	localparam int         FDRD_DD_BIT      = 6;
	localparam int         FDRD_SKIP_BIT    = 5;
	localparam int         FDRD_HEAD_BIT    = 2;
	localparam int         FDRD_IDX_SEL     = 1;
	localparam int         FDRD_IDX_C       = 2;
	localparam int         FDRD_IDX_H       = 3;
	localparam int         FDRD_IDX_R       = 4;
	localparam int         FDRD_IDX_N       = 5;
	localparam int         FDRD_IDX_EOT     = 6;
	localparam int         FDRD_IDX_DTL     = 8;
	localparam logic [1:0] FDRD_IC_NORMAL   = 2'h0;
	localparam logic [1:0] FDRD_IC_ABNORMAL = 2'h1;
	localparam logic [1:0] FDRD_IC_INVALID  = 2'h2;
	localparam int         FDRD_ST1_DATAERR = 5;
	localparam int         FDRD_ST1_OVERRUN = 4;
	localparam int         FDRD_ST1_NODATA  = 2;
	localparam int         FDRD_ST2_CTRLMK  = 6;
	localparam int         FDRD_MSR_REQ     = 7;
	localparam int         FDRD_MSR_DIR     = 6;
	localparam int         FDRD_MSR_EXEC    = 5;
	localparam int         FDRD_MSR_BUSY    = 4;
	localparam int         FDRD_LEN_BASE    = 7;
	localparam logic [2:0] FDRD_N_MAX       = 3'h7;
	localparam logic [7:0] FDRD_FIRST_SECT  = 8'h01;
	localparam logic [7:0] FDRD_STEP_ONE    = 8'h01;
	localparam logic [7:0] FDRD_ZERO_BYTE   = 8'h00;

	typedef enum logic [2:0] {
		FDRD_S_CMD,
		FDRD_S_REQ,
		FDRD_S_WAIT_ID,
		FDRD_S_DATA,
		FDRD_S_CRC,
		FDRD_S_DRAIN,
		FDRD_S_RESULT
	} fdrd_state_t;
endpackage

/* fdrd_read_data.sv */
// read-data command sequencer: command, execution and result phases
`timescale 1ns/10ps
module fdrd_read_data (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// host command and data port
	input  wire logic        i_cmd_wr,
	input  wire logic [7:0]  i_cmd_byte,
	output logic             o_cmd_ready,
	input  wire logic        i_host_rd,
	input  wire logic        i_port_select_line,
	output logic [7:0]       o_host_rdata,
	output logic             o_host_data_avail,
	// scan and write options
	input  wire logic        i_scan_enable,
	input  wire logic [1:0]  i_scan_sector_step,
	input  wire logic        i_write_mode,
	output logic             o_write_fill,
	// status
	output logic             o_busy,
	output logic             o_result_phase,
	output logic [7:0]       o_result_status_three,
	// drive side
	output logic             o_sector_req,
	output logic [7:0]       o_req_cyl,
	output logic [7:0]       o_req_head_id,
	output logic [7:0]       o_req_sector,
	output logic [7:0]       o_req_size,
	output logic             o_head_select_bit,
	output logic [1:0]       o_unit_drive_select,
	output logic             o_double_density_select,
	input  wire logic        i_id_found,
	input  wire logic        i_deleted_mark,
	input  wire logic        i_no_id,
	input  wire logic        i_disk_valid,
	input  wire logic [7:0]  i_disk_byte,
	input  wire logic        i_crc_done,
	input  wire logic        i_crc_error,
	input  wire logic        i_terminal_count
);
	import fdrd_pkg::*;

	typedef struct packed {
		fdrd_state_t     st;
		logic [8:0][7:0] cmd;
		logic [3:0]      idx;
		logic [7:0]      head_id;
		logic [7:0]      sect;
		logic            head;
		logic [7:0]      host_byte;
		logic            host_full;
		logic            tc_meta;
		logic            tc_sync;
		logic            tc_seen;
		logic            skipping;
		logic [7:0]      st0;
		logic [7:0]      st1;
		logic [7:0]      st2;
		logic [7:0]      st3;
		logic [2:0]      ridx;
		logic [2:0]      rlen;
	} fdrd_regs_t;

	fdrd_regs_t  r;
	fdrd_regs_t  r_nxt;
	fdrd_sect_if sif ();

	logic       rd_sel;
	logic       host_load;
	logic       pop_result;
	logic       mt;
	logic       skip_del;
	logic [7:0] last_sector_on_track;
	logic [7:0] step;
	logic [7:0] msr;
	logic       at_eot;
	logic       to_side_one;

	// result byte order: three status bytes, then C, H, R, N
	function automatic logic [7:0] fdrd_res_byte(input fdrd_regs_t s, input logic [2:0] i);
		logic [7:0] b;
		b = FDRD_ZERO_BYTE;
		unique case (i)
			3'h0: b = s.st0;
			3'h1: b = s.st1;
			3'h2: b = s.st2;
			3'h3: b = s.cmd[FDRD_IDX_C];
			3'h4: b = s.head_id;
			3'h5: b = s.sect;
			3'h6: b = s.cmd[FDRD_IDX_N];
			default: b = FDRD_ZERO_BYTE;
		endcase
		return b;
	endfunction

	fdrd_sector_count u_count (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.sif     (sif)
	);

	always_comb begin
		r_nxt      = r;
		mt         = r.cmd[0][FDRD_MT_BIT];
		skip_del   = r.cmd[0][FDRD_SKIP_BIT];
		last_sector_on_track        = r.cmd[FDRD_IDX_EOT];
		// scan walks by the programmed step, a plain read by one
		step       = i_scan_enable ? {6'h00, i_scan_sector_step} : FDRD_STEP_ONE;
		at_eot     = (r.sect == last_sector_on_track);
		to_side_one = mt && !r.head;
		rd_sel     = i_host_rd && i_port_select_line;
		pop_result = rd_sel && (r.st == FDRD_S_RESULT);
		// nothing goes to the host past terminal count or inside a skipped sector
		host_load  = (r.st == FDRD_S_DATA) && i_disk_valid && sif.deliver
			&& !r.tc_seen && !r.skipping;
		sif.start       = (r.st == FDRD_S_WAIT_ID) && i_id_found;
		sif.byte_stb    = (r.st == FDRD_S_DATA) && i_disk_valid;
		sif.size_code   = r.cmd[FDRD_IDX_N];
		sif.short_count = r.cmd[FDRD_IDX_DTL];
		// terminal count pin, two flops before use
		r_nxt.tc_meta = i_terminal_count;
		r_nxt.tc_sync = r.tc_meta;
		if ((r.st != FDRD_S_CMD) && (r.st != FDRD_S_RESULT) && r.tc_sync) begin
			r_nxt.tc_seen = 1'b1;
		end
		// host data holding byte: a load in the same cycle as a pop wins
		if (rd_sel && r.host_full) begin
			r_nxt.host_full = 1'b0;
		end
		if (host_load) begin
			if (r.host_full && !rd_sel) begin
				r_nxt.st1[FDRD_ST1_OVERRUN] = 1'b1;
			end else begin
				r_nxt.host_byte = i_disk_byte;
				r_nxt.host_full = 1'b1;
			end
		end
		unique case (r.st)
			FDRD_S_CMD: begin
				if (i_cmd_wr) begin
					r_nxt.cmd[r.idx] = i_cmd_byte;
					r_nxt.idx        = r.idx + 4'h1;
					if ((r.idx == 4'h0) && (i_cmd_byte[FDRD_OP_MSB:0] != FDRD_OP_READ)) begin
						r_nxt.idx  = 4'h0;
						r_nxt.st0  = {FDRD_IC_INVALID, 6'h00};
						r_nxt.rlen = FDRD_RES_INVALID;
						r_nxt.ridx = 3'h0;
						r_nxt.st   = FDRD_S_RESULT;
					end else if (r.idx == FDRD_CMD_LAST) begin
						r_nxt.idx      = 4'h0;
						r_nxt.head     = r.cmd[FDRD_IDX_SEL][FDRD_HEAD_BIT];
						r_nxt.head_id  = r.cmd[FDRD_IDX_H];
						r_nxt.sect     = r.cmd[FDRD_IDX_R];
						r_nxt.tc_seen  = 1'b0;
						r_nxt.st1      = FDRD_ZERO_BYTE;
						r_nxt.st2      = FDRD_ZERO_BYTE;
						r_nxt.st       = FDRD_S_REQ;
					end
				end
			end
			FDRD_S_REQ: begin
				r_nxt.st = FDRD_S_WAIT_ID;
			end
			FDRD_S_WAIT_ID: begin
				if (i_no_id) begin
					r_nxt.st1[FDRD_ST1_NODATA] = 1'b1;
					r_nxt.st0[7:6]             = FDRD_IC_ABNORMAL;
					r_nxt.st                   = FDRD_S_DRAIN;
				end else if (i_id_found) begin
					r_nxt.skipping = i_deleted_mark && skip_del;
					if (i_deleted_mark) begin
						r_nxt.st2[FDRD_ST2_CTRLMK] = 1'b1;
					end
					r_nxt.st = FDRD_S_DATA;
				end
			end
			FDRD_S_DATA: begin
				if (i_disk_valid && sif.last) begin
					r_nxt.st = FDRD_S_CRC;
				end
			end
			FDRD_S_CRC: begin
				if (i_crc_done) begin
					r_nxt.skipping = 1'b0;
					if (i_crc_error) begin
						r_nxt.st1[FDRD_ST1_DATAERR] = 1'b1;
						r_nxt.st0[7:6]              = FDRD_IC_ABNORMAL;
						r_nxt.st                    = FDRD_S_DRAIN;
					end else if (r.tc_seen) begin
						r_nxt.st = FDRD_S_DRAIN;
					end else if (at_eot && to_side_one) begin
						r_nxt.head    = 1'b1;
						r_nxt.head_id = 8'h01;
						r_nxt.sect    = FDRD_FIRST_SECT;
						r_nxt.st      = FDRD_S_REQ;
					end else if (at_eot) begin
						r_nxt.st = FDRD_S_DRAIN;
					end else begin
						r_nxt.sect = r.sect + step;
						r_nxt.st   = FDRD_S_REQ;
					end
				end
			end
			FDRD_S_DRAIN: begin
				// wait for the host to take the last byte before results
				if (!r.host_full || rd_sel) begin
					r_nxt.st0[2]   = r.head;
					r_nxt.st0[1:0] = r.cmd[FDRD_IDX_SEL][1:0];
					r_nxt.st3      = {5'h00, r.head, r.cmd[FDRD_IDX_SEL][1:0]};
					r_nxt.ridx     = 3'h0;
					r_nxt.rlen     = FDRD_RES_LEN;
					r_nxt.st       = FDRD_S_RESULT;
				end
			end
			FDRD_S_RESULT: begin
				if (pop_result) begin
					r_nxt.ridx = r.ridx + 3'h1;
					if (r.ridx == r.rlen - 3'h1) begin
						r_nxt.st0 = FDRD_ZERO_BYTE;
						r_nxt.st  = FDRD_S_CMD;
					end
				end
			end
		endcase
		msr = FDRD_ZERO_BYTE;
		msr[FDRD_MSR_REQ]  = (r.st == FDRD_S_CMD) || r.host_full || (r.st == FDRD_S_RESULT);
		msr[FDRD_MSR_DIR]  = r.host_full || (r.st == FDRD_S_RESULT);
		msr[FDRD_MSR_EXEC] = (r.st != FDRD_S_CMD) && (r.st != FDRD_S_RESULT);
		msr[FDRD_MSR_BUSY] = (r.st != FDRD_S_CMD);
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign o_cmd_ready             = (r.st == FDRD_S_CMD);
	// status lives apart from the result bytes; port select picks which
	assign o_host_rdata            = !i_port_select_line ? msr
		: ((r.st == FDRD_S_RESULT) ? fdrd_res_byte(r, r.ridx) : r.host_byte);
	assign o_host_data_avail       = r.host_full;
	assign o_write_fill            = i_write_mode && (r.st == FDRD_S_DATA) && !sif.deliver;
	assign o_busy                  = (r.st != FDRD_S_CMD);
	assign o_result_phase          = (r.st == FDRD_S_RESULT);
	assign o_result_status_three   = (r.st == FDRD_S_RESULT) ? r.st3 : FDRD_ZERO_BYTE;
	assign o_sector_req            = (r.st == FDRD_S_REQ);
	assign o_req_cyl               = r.cmd[FDRD_IDX_C];
	assign o_req_head_id           = r.head_id;
	assign o_req_sector            = r.sect;
	assign o_req_size              = r.cmd[FDRD_IDX_N];
	assign o_head_select_bit       = r.head;
	assign o_unit_drive_select     = r.cmd[FDRD_IDX_SEL][1:0];
	assign o_double_density_select = r.cmd[0][FDRD_DD_BIT];

	a_nine_bytes: assert property (@(posedge i_clock) disable iff (i_rst)
		(r.st == FDRD_S_CMD && i_cmd_wr && r.idx != 4'h0 && r.idx < FDRD_CMD_LAST) |=> r.st == FDRD_S_CMD)
		else $error("execution began before nine bytes");
	a_exec_start: assert property (@(posedge i_clock) disable iff (i_rst)
		(r.st == FDRD_S_CMD && i_cmd_wr && r.idx == FDRD_CMD_LAST) |=> o_sector_req ##1 !o_sector_req)
		else $error("ninth byte did not start execution");
	a_sector_step: assert property (@(posedge i_clock) disable iff (i_rst)
		(r.st == FDRD_S_CRC && i_crc_done && !i_crc_error && !r.tc_seen && !at_eot && !i_scan_enable)
		|=> r.sect == $past(r.sect) + 8'h01 && o_sector_req)
		else $error("sector address did not advance by one");
	a_tc_no_data: assert property (@(posedge i_clock) disable iff (i_rst)
		(r.tc_seen && r.st == FDRD_S_DATA) |-> !host_load)
		else $error("data delivered after terminal count");
	a_tc_full_sector: assert property (@(posedge i_clock) disable iff (i_rst)
		(r.tc_seen && r.st == FDRD_S_DATA && !(i_disk_valid && sif.last)) |=> r.st == FDRD_S_DATA)
		else $error("sector abandoned early after terminal count");
	a_side_one: assert property (@(posedge i_clock) disable iff (i_rst)
		(r.st == FDRD_S_CRC && i_crc_done && !i_crc_error && !r.tc_seen && at_eot && to_side_one)
		|=> o_head_select_bit && o_req_sector == FDRD_FIRST_SECT && o_sector_req)
		else $error("multi-track did not move to side one sector one");
	a_eot_stop: assert property (@(posedge i_clock) disable iff (i_rst)
		(r.st == FDRD_S_CRC && i_crc_done && !i_crc_error && at_eot && !to_side_one)
		|=> !o_sector_req [*2])
		else $error("transfer continued past last sector");
	a_skip_deleted: assert property (@(posedge i_clock) disable iff (i_rst)
		(r.skipping && r.st == FDRD_S_DATA && i_disk_valid) |-> !host_load)
		else $error("deleted sector data reached host");
	a_result_idle: assert property (@(posedge i_clock) disable iff (i_rst)
		(pop_result && r.ridx == r.rlen - 3'h1) |=> o_cmd_ready && !o_result_phase)
		else $error("no return to idle after last result byte");
	a_write_fill: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_write_mode && r.st == FDRD_S_DATA && r.cmd[FDRD_IDX_N] == 8'h00
		&& !sif.deliver) |-> o_write_fill)
		else $error("short write sector not zero filled");
endmodule // fdrd_read_data

/* fdrd_sect_if.sv */
// carrier between sequencer and sector byte counter
`timescale 1ns/10ps
interface fdrd_sect_if;
	logic       start;
	logic       byte_stb;
	logic [7:0] size_code;
	logic [7:0] short_count;
	logic       deliver;
	logic       last;
	modport ctl (output start, output byte_stb, output size_code, output short_count,
		input deliver, input last);
	modport cnt (input start, input byte_stb, input size_code, input short_count,
		output deliver, output last);
endinterface

/* fdrd_sector_count.sv */
// sector byte counter: sector length and short-sector window
`timescale 1ns/10ps
module fdrd_sector_count (
	// clock and reset
	input  wire logic  i_clock,
	input  wire logic  i_rst,
	// sequencer side
	fdrd_sect_if.cnt   sif
);
	import fdrd_pkg::*;

	typedef struct packed {
		logic [14:0] count;
	} fdrd_cnt_t;

	fdrd_cnt_t   r;
	fdrd_cnt_t   r_nxt;
	logic [2:0]  n_eff;
	logic [14:0] sect_len;

	always_comb begin
		// codes above the largest size clamp, so the counter never overflows
		n_eff    = (sif.size_code > {5'h00, FDRD_N_MAX}) ? FDRD_N_MAX : sif.size_code[2:0];
		sect_len = 15'(15'h0001 << (FDRD_LEN_BASE + int'(n_eff)));
		r_nxt    = r;
		if (sif.start) begin
			r_nxt.count = 15'h0000;
		end else if (sif.byte_stb) begin
			r_nxt.count = r.count + 15'h0001;
		end
		sif.last    = (r.count == sect_len - 15'h0001);
		// short count applies only to 128-byte sectors; the tail is still read
		sif.deliver = (n_eff != 3'h0) || (r.count < {7'h00, sif.short_count});
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	a_count_clear: assert property (@(posedge i_clock) disable iff (i_rst)
		sif.start |=> r.count == 15'h0000) else $error("counter not cleared at sector start");
endmodule // fdrd_sector_count

/* testbench.sv */
// self-checking bench for the read-data command sequencer
`timescale 1ns/10ps
module testbench;
	import fdrd_pkg::*;
	logic        i_clock, i_rst, i_cmd_wr, i_host_rd, i_port_select_line;
	logic        i_scan_enable, i_terminal_count, crc_bad, tc_mode;
	logic [1:0]  i_scan_sector_step, o_unit_drive_select;
	logic [2:0]  gap;
	logic [7:0]  i_cmd_byte, o_host_rdata, o_result_status_three, o_req_cyl, o_req_head_id;
	logic [7:0]  o_req_sector, o_req_size, disk_byte, v;
	logic        o_cmd_ready, o_host_data_avail, o_busy, o_result_phase, o_sector_req;
	logic        o_head_select_bit, o_double_density_select, id_found, disk_valid, crc_done, crc_error;
	logic [15:0] reqs[$], exp_reqs[$];
	int          seed = 3, errors = 0, tests_run = 0, nbytes, fills;
	logic        del_mark, sk, wr_mode, write_fill;

	fdrd_read_data fdrd_read_data_inst (
		.i_clock, .i_rst, .i_cmd_wr, .i_cmd_byte, .o_cmd_ready, .i_host_rd, .i_port_select_line,
		.o_host_rdata, .o_host_data_avail, .i_scan_enable, .i_scan_sector_step, .i_write_mode(wr_mode),
		.o_write_fill(write_fill), .o_busy, .o_result_phase, .o_result_status_three, .o_sector_req, .o_req_cyl,
		.o_req_head_id, .o_req_sector, .o_req_size, .o_head_select_bit, .o_unit_drive_select,
		.o_double_density_select, .i_id_found(id_found), .i_deleted_mark(del_mark), .i_no_id(1'b0),
		.i_disk_valid(disk_valid), .i_disk_byte(disk_byte), .i_crc_done(crc_done),
		.i_crc_error(crc_error), .i_terminal_count);

	fdrd_drive_model fdrd_drive_model_inst (
		.i_clock, .i_rst, .i_sector_req(o_sector_req), .i_req_sector(o_req_sector),
		.i_req_size(o_req_size), .i_gap(gap), .i_crc_bad(crc_bad), .o_id_found(id_found),
		.o_disk_valid(disk_valid), .o_disk_byte(disk_byte), .o_crc_done(crc_done), .o_crc_error(crc_error));

	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		if (o_sector_req) reqs.push_back({o_req_head_id, o_req_sector});
		// zero-fill strobes seen on real disk bytes only
		if (write_fill && disk_valid) fills++;
	end

	function automatic logic [7:0] exp_byte(input logic [7:0] sec, input int idx);
		return (sec * 8'h11) ^ idx[7:0];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one whole command: nine bytes in, data drained, result bytes read
	task automatic cmd(input logic mt, input logic hd, input logic [7:0] r, n, last_sector_on_track, short_sector_byte_count, input logic bad);
		logic [7:0]  b[9];
		logic [7:0]  res[7];
		logic [7:0]  c, sel;
		logic [15:0] last;
		int          k, t, nres, per;
		c = 8'($random(seed));
		sel = {5'h00, hd, 1'b0, c[2]};
		gap = {1'b1, c[4:3]};
		nres = bad ? 1 : 7;
		per = (n == 8'h00 && short_sector_byte_count < 8'h80) ? int'(short_sector_byte_count) : 128 << n[2:0];
		b = '{{mt, c[5], sk, bad ? 5'h1F : FDRD_OP_READ}, sel, c, {7'h00, hd}, r, n, last_sector_on_track, 8'h1B, short_sector_byte_count};
		reqs.delete();
		nbytes = 0;
		k = 0;
		t = 0;
		for (int i = 0; i < 9; i++) begin
			@(posedge i_clock);
			#1 i_cmd_wr = 1'b1;
			i_cmd_byte = b[i];
		end
		@(posedge i_clock);
		#1 i_cmd_wr = 1'b0;
		if (!bad) begin
			while (!o_sector_req && t < 20) begin
				@(posedge i_clock);
				#1 t++;
			end
			check({o_req_cyl, o_head_select_bit, o_req_sector, o_req_size}, {c, hd, r, n});
			check(o_unit_drive_select, sel[1:0]);
			check(o_double_density_select, c[5]);
			check({o_busy, o_cmd_ready}, 2'b10);
		end
		t = 0;
		while (!(k == nres && !i_host_rd) && t < 40000) begin
			@(posedge i_clock);
			#1 t++;
			if (i_host_rd) i_host_rd = 1'b0;
			else if (o_result_phase && k < nres) begin
				if (k == 0 && !mt && !bad) check(o_result_status_three, sel);
				res[k] = o_host_rdata;
				k++;
				i_host_rd = 1'b1;
			end else if (o_host_data_avail && !o_result_phase) begin
				check(o_host_rdata, exp_byte(reqs[nbytes / per][7:0], nbytes % per));
				nbytes++;
				i_host_rd = 1'b1;
			end
		end
		check(t < 40000, 1'b1);
		@(posedge i_clock);
		#1 check(o_cmd_ready, 1'b1);
		if (bad) check(res[0], 8'h80);
		else begin
			last = reqs[reqs.size() - 1];
			check(reqs.size(), exp_reqs.size());
			foreach (exp_reqs[i]) check(reqs[i], exp_reqs[i]);
			check(tc_mode ? nbytes < per : nbytes == (sk ? 0 : per * reqs.size()), 1'b1);
			check(res[0], {crc_bad ? FDRD_IC_ABNORMAL : FDRD_IC_NORMAL, 3'h0, last[8], sel[1:0]});
			check({res[1], res[2]}, {2'h0, crc_bad, 6'h00, del_mark, 6'h00});
			check({res[3], res[4], res[5], res[6]}, {c, last, n});
		end
	endtask

	initial begin
		repeat (90000) @(posedge i_clock);
		errors++;
		finish_test;
	end

	initial begin
		i_rst = 1'b1;
		i_cmd_wr = 1'b0;
		i_cmd_byte = 8'h00;
		i_host_rd = 1'b0;
		i_port_select_line = 1'b0;
		i_scan_enable = 1'b0;
		i_scan_sector_step = 2'h1;
		i_terminal_count = 1'b0;
		crc_bad = 1'b0;
		tc_mode = 1'b0;
		gap = 3'h4;
		del_mark = 1'b0;
		sk = 1'b0;
		wr_mode = 1'b0;
		fills = 0;
		repeat (4) @(posedge i_clock);
		check({o_cmd_ready, o_busy, o_host_rdata}, {2'b10, 8'h80});
		#1 i_rst = 1'b0;
		i_port_select_line = 1'b1;
		// short 128-byte sector, random short count and head
		v = 8'($random(seed));
		exp_reqs = '{{7'h00, v[7], 8'h09}};
		wr_mode = 1'b1;
		cmd(1'b0, v[7], 8'h09, 8'h00, 8'h09, {1'b0, v[6:0] | 7'h01}, 1'b0);
		wr_mode = 1'b0;
		check(fills, 128 - int'(v[6:0] | 7'h01));
		// multi-sector 256-byte run, back to back with the last command
		exp_reqs = '{16'h0103, 16'h0104, 16'h0105};
		cmd(1'b0, 1'b1, 8'h03, 8'h01, 8'h05, 8'hFF, 1'b0);
		// multi-track wraps to sector one on side one
		exp_reqs = '{16'h0002, 16'h0101, 16'h0102};
		cmd(1'b1, 1'b0, 8'h02, 8'h00, 8'h02, 8'hFF, 1'b0);
		i_scan_enable = 1'b1;
		i_scan_sector_step = 2'h2;
		exp_reqs = '{16'h0001, 16'h0003, 16'h0005};
		cmd(1'b0, 1'b0, 8'h01, 8'h00, 8'h05, 8'hFF, 1'b0);
		i_scan_enable = 1'b0;
		crc_bad = 1'b1;
		exp_reqs = '{16'h0007};
		cmd(1'b0, 1'b0, 8'h07, 8'h00, 8'h07, 8'hFF, 1'b0);
		crc_bad = 1'b0;
		// deleted sector with bypass set: read through, nothing reaches the host
		del_mark = 1'b1;
		sk = 1'b1;
		exp_reqs = '{16'h0004};
		cmd(1'b0, 1'b0, 8'h04, 8'h00, 8'h04, 8'hFF, 1'b0);
		del_mark = 1'b0;
		sk = 1'b0;
		// terminal count in mid-sector stops delivery, no further sector
		tc_mode = 1'b1;
		exp_reqs = '{16'h0101};
		fork
			cmd(1'b0, 1'b1, 8'h01, 8'h01, 8'h09, 8'hFF, 1'b0);
			begin
				wait (nbytes == 40);
				@(posedge i_clock);
				#1 i_terminal_count = 1'b1;
				repeat (4) @(posedge i_clock);
				#1 i_terminal_count = 1'b0;
			end
		join
		tc_mode = 1'b0;
		cmd(1'b0, 1'b0, 8'h01, 8'h00, 8'h01, 8'hFF, 1'b1);
		finish_test;
	end
endmodule // testbench
